// *** logic/hsd_pkg.sv ***
// Constants and types shared by the haptic serial input, protection and diagnostic register bank.
`default_nettype none
package hsd_pkg;
  // System clock rate.
  localparam int HSD_CLK_HZ = 25_000_000;
  // Protection dwell unit is one three-thousandth of a second.
  localparam int HSD_PROT_TICK_HZ = 3000;
  localparam int HSD_PROT_TICK_CYC = HSD_CLK_HZ / HSD_PROT_TICK_HZ;
  // Fastest measurement converter clock; slower codes double the period.
  localparam int HSD_ADC_BASE_HZ = 12_000_000;
  localparam int HSD_ADC_BASE_CYC = HSD_CLK_HZ / HSD_ADC_BASE_HZ;
  // Register offsets.
  localparam logic [7:0] HSD_ADDR_FMT = 8'h4a;
  localparam logic [7:0] HSD_ADDR_CHAN = 8'h4b;
  localparam logic [7:0] HSD_ADDR_OPROT = 8'h4c;
  localparam logic [7:0] HSD_ADDR_SHDN = 8'h4d;
  localparam logic [7:0] HSD_ADDR_IPLVL = 8'h4e;
  localparam logic [7:0] HSD_ADDR_IPTIME = 8'h4f;
  localparam logic [7:0] HSD_ADDR_DIAG = 8'h51;
  localparam logic [7:0] HSD_ADDR_MSTART = 8'h52;
  localparam logic [7:0] HSD_ADDR_RLHI = 8'h53;
  localparam logic [7:0] HSD_ADDR_VBHI = 8'h55;
  localparam logic [7:0] HSD_ADDR_MLO = 8'h57;
  // Values after reset.
  localparam logic [7:0] HSD_RST_FMT = 8'h3a;
  localparam logic [7:0] HSD_RST_CHAN = 8'h06;
  localparam logic [7:0] HSD_RST_OPROT = 8'ha0;
  localparam logic [7:0] HSD_RST_SHDN = 8'h28;
  localparam logic [7:0] HSD_RST_IPLVL = 8'hbf;
  localparam logic [7:0] HSD_RST_IPTIME = 8'h32;
  localparam logic [7:0] HSD_RST_DIAG = 8'h02;
  localparam logic [7:0] HSD_RST_MSTART = 8'h00;
  // Field positions.
  localparam int HSD_CH_SWAP = 4;
  localparam int HSD_CH_BINV = 3;
  localparam int HSD_CH_SEL = 2;
  localparam int HSD_CH_INT = 1;
  localparam int HSD_CH_EN = 0;
  localparam int HSD_PROT_EN = 7;
  localparam int HSD_SHDN_WAVE = 4;
  localparam int HSD_DIAG_KIND = 4;
  localparam int HSD_MS_BATT = 1;
  localparam int HSD_MS_DIAG = 0;
  // Output protection trip level in 1/128 of the boost rail.
  localparam logic [6:0] HSD_OPROT_LEVEL = 7'h7c;
  // Frame formats and bit-clock ratios.
  typedef enum logic [1:0] {HSD_FMT_I2S = 2'h0, HSD_FMT_MSBJ = 2'h1, HSD_FMT_LSBJ = 2'h2,
                            HSD_FMT_I2S_ALT = 2'h3} hsd_fmt_t;
  typedef enum logic [1:0] {HSD_BCK_32 = 2'h0, HSD_BCK_48 = 2'h1, HSD_BCK_64 = 2'h2,
                            HSD_BCK_RSVD = 2'h3} hsd_ratio_t;
  // Measurement engine states.
  typedef enum logic [2:0] {HSD_M_IDLE = 3'h1, HSD_M_BATT = 3'h2, HSD_M_DIAG = 3'h4} hsd_meas_t;
endpackage : hsd_pkg
`default_nettype wire

// *** logic/hsd_regbank.sv ***
// Serial audio receiver, bridge protection and measurement registers of the haptic driver.
//
// Summary of operation
// (R1) Frame format: I2S, MSB- or LSB-justified.
// (R2) Sample width capped by bit-clock ratio.
// (R3) Ratio field selects 32x, 48x or 64x.
// (R4) Almost-full asserts at threshold plus one.
// (R5) Swap bit exchanges left and right.
// (R6) Invert bit samples on opposite edge.
// (R7) Channel select picks right or left.
// (R8) Interruptible bit lets others pre-empt playback.
// (R9) Playback runs only while enable set.
// (R10) Output at 124/128 rail trips pull-low.
// (R11) Output dwell in 1/3000 s units.
// (R12) Shutdown bit picks half or full wave.
// (R13) Output at programmed level trips pull-low.
// (R14) Input dwell in 1/3000 s units.
// (R15) Converter clock divider doubles per code.
// (R16) Battery start bit runs battery measurement.
// (R17) Diagnostic start bit runs resistance measurement.
// (R18) Resistance code split high byte, bits 1:0.
// (R19) Battery code split high byte, bits 5:4.
// (R20) Pin sharing moves data and word clock.
// (R21) Results hold until next same-kind measurement.
`default_nettype none

// Sample FIFO with valid and ready on both sides.
module hsd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  // Storage, pointers and fill count.
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } hsd_fifo_state_t;
  hsd_fifo_state_t st_reg, st_next;
  logic push;
  logic pop;

  // Pointers wrap naturally, so the depth must be a power of two.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2.");
  end

  assign in_ready = (st_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (st_reg.cnt != '0);
  assign out_data = st_reg.mem[st_reg.rp];
  assign count = st_reg.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: write at the tail, read at the head.
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wp] = in_data;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop) begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end else if (pop && !push) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : hsd_fifo

// Register bank with serial audio receive path, protection timers and measurement sequencer.
module hsd_regbank
  import hsd_pkg::*;
#(
  parameter int TICK_CYCLES = HSD_PROT_TICK_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Register access port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Serial audio pins and sharing select.
  input wire logic bck_pin,
  input wire logic ws_pin,
  input wire logic sd_pin,
  input wire logic third_trigger_pin,
  input wire logic second_trigger_pin,
  input wire logic serial_pin_share,
  // Received sample stream.
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [31:0] sample_data,
  output logic rx_almost_full,
  output logic rx_overrun,
  // Playback control.
  output logic serial_play_active,
  output logic serial_preemptible,
  // Bridge protection.
  input wire logic [6:0] pos_level,
  input wire logic [6:0] neg_level,
  output logic bridge_pull_low,
  output logic shutdown_full_wave,
  // Measurement engine.
  output logic adc_clk_en,
  output logic meas_start,
  output logic meas_battery,
  output logic diagnostic_kind_sel,
  input wire logic meas_done,
  input wire logic [9:0] meas_code
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int DW = $clog2(HSD_ADC_BASE_CYC * 128 + 1);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // Refuse settings the counters cannot serve.
  if (TICK_CYCLES < 1 || HSD_ADC_BASE_CYC < 1 || FIFO_DEPTH < 4) begin : g_bad_param
    $error("Tick count, converter base divider or FIFO depth out of range.");
  end

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] fmt;          // Frame format, width, ratio, threshold.
    logic [7:0] chan;         // Swap, invert, select, interruptible, enable.
    logic [7:0] oprot;        // Output protection enable and dwell.
    logic [7:0] shdn;         // Shutdown modulation.
    logic [7:0] iplvl;        // Input protection enable and level.
    logic [7:0] iptime;       // Input protection dwell.
    logic [7:0] diag;         // Diagnostic kind and converter clock code.
    logic [7:0] mstart;       // Measurement start bits.
    logic [9:0] rl_code;      // Last load resistance result.
    logic [9:0] vb_code;      // Last battery voltage result.
    logic [7:0] rdata;        // Read data.
    logic [1:0] s_bck;        // Pin synchronisers.
    logic [1:0] s_ws;
    logic [1:0] s_sd;
    logic [1:0] s_t3;
    logic [1:0] s_t2;
    logic bck_d;              // Delayed bit clock for edge detection.
    logic ws_last;            // Word clock at the previous sampling edge.
    logic [31:0] shreg;       // Incoming bit shifter.
    logic pend_v;             // Word waiting for the FIFO.
    logic [31:0] pend;
    logic out_v;              // Output stage.
    logic [31:0] out_d;
    logic almost;
    logic overrun;
    logic [TW-1:0] tick_cnt;  // Dwell tick divider.
    logic tick;
    logic [6:0] op_cnt;
    logic [7:0] ip_cnt;
    logic op_trip;
    logic ip_trip;
    logic pull;
    logic [DW-1:0] adc_cnt;   // Converter clock divider.
    logic adc_en;
    hsd_meas_t mstate;
    logic mpulse;
    logic mbatt;
  } hsd_state_t;

  hsd_state_t st_reg, st_next;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic [CW-1:0] fifo_cnt;
  logic op_cond;
  logic ip_cond;

  // Effective sample width after the ratio cap.
  function automatic logic [5:0] eff_width(input logic [1:0] fs, input logic [1:0] bck);
    logic [1:0] c;
    c = fs;
    if (bck == HSD_BCK_48 && fs == 2'h3) begin
      c = 2'h2;
    end
    if (bck == HSD_BCK_32) begin
      c = 2'h0;
    end
    case (c)
      2'h0: eff_width = 6'h10;
      2'h1: eff_width = 6'h14;
      2'h2: eff_width = 6'h18;
      default: eff_width = 6'h20;
    endcase
  endfunction : eff_width

  // Bits per channel slot; the reserved ratio is treated as 64x.
  function automatic logic [5:0] slot_bits(input logic [1:0] bck);
    case (bck)
      HSD_BCK_32: slot_bits = 6'h10;
      HSD_BCK_48: slot_bits = 6'h18;
      default: slot_bits = 6'h20;
    endcase
  endfunction : slot_bits

  // Sample buffer between the receiver and the output stage.
  hsd_fifo #(.W(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(st_reg.pend_v),
    .in_ready(fifo_in_ready),
    .in_data(st_reg.pend),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_cnt)
  );

  // The output stage refills when empty or when its word is taken.
  assign fifo_out_ready = !st_reg.out_v || sample_ready;

  // Either bridge output at or above the fixed or programmed level.
  assign op_cond = st_reg.oprot[HSD_PROT_EN] &&
                   (pos_level >= HSD_OPROT_LEVEL || neg_level >= HSD_OPROT_LEVEL); // see (R10)
  assign ip_cond = st_reg.iplvl[HSD_PROT_EN] &&
                   (pos_level >= st_reg.iplvl[6:0] || neg_level >= st_reg.iplvl[6:0]); // see (R13)

  // Next-state logic for every part of the block.
  always_comb begin
    logic ws;
    logic sd;
    logic edge_hit;
    logic left;
    logic is_i2s;
    logic [31:0] shin;
    logic [31:0] word;
    logic [31:0] val;
    logic [5:0] w;
    logic [5:0] slot;
    ws = 1'b0;
    sd = 1'b0;
    edge_hit = 1'b0;
    left = 1'b0;
    is_i2s = 1'b0;
    shin = '0;
    word = '0;
    val = '0;
    w = '0;
    slot = '0;
    st_next = st_reg;
    st_next.mpulse = 1'b0;

    // Two-stage synchronisers on every pin; only the second stage is read.
    st_next.s_bck = {st_reg.s_bck[0], bck_pin};
    st_next.s_ws = {st_reg.s_ws[0], ws_pin};
    st_next.s_sd = {st_reg.s_sd[0], sd_pin};
    st_next.s_t3 = {st_reg.s_t3[0], third_trigger_pin};
    st_next.s_t2 = {st_reg.s_t2[0], second_trigger_pin};
    st_next.bck_d = st_reg.s_bck[1];

    // Shared trigger pins carry data and word clock when sharing is on.
    ws = serial_pin_share ? st_reg.s_t2[1] : st_reg.s_ws[1]; // see (R20)
    sd = serial_pin_share ? st_reg.s_t3[1] : st_reg.s_sd[1]; // see (R20)

    // Sample on the rising edge, or the falling edge when inverted.
    if (st_reg.chan[HSD_CH_BINV]) begin
      edge_hit = !st_reg.s_bck[1] && st_reg.bck_d; // see (R6)
    end else begin
      edge_hit = st_reg.s_bck[1] && !st_reg.bck_d;
    end

    // A pending word leaves once the FIFO accepts it.
    if (st_reg.pend_v && fifo_in_ready) begin
      st_next.pend_v = 1'b0;
    end

    // Receiver runs only while enabled.
    if (!st_reg.chan[HSD_CH_EN]) begin // see (R9)
      st_next.pend_v = 1'b0;
      st_next.overrun = 1'b0;
      st_next.shreg = '0;
    end else if (edge_hit) begin
      is_i2s = (st_reg.fmt[7:6] == HSD_FMT_I2S) || (st_reg.fmt[7:6] == HSD_FMT_I2S_ALT); // see (R1)
      w = eff_width(st_reg.fmt[5:4], st_reg.fmt[3:2]); // see (R2)
      slot = slot_bits(st_reg.fmt[3:2]); // see (R3)
      shin = {st_reg.shreg[30:0], sd};
      st_next.shreg = shin;
      st_next.ws_last = ws;
      if (ws != st_reg.ws_last) begin
        // Standard framing ends a slot one bit after the word clock changes.
        word = is_i2s ? shin : st_reg.shreg; // see (R1)
        left = is_i2s ? !st_reg.ws_last : st_reg.ws_last;
        if (st_reg.chan[HSD_CH_SWAP]) begin
          left = !left; // see (R5)
        end
        if (st_reg.fmt[7:6] == HSD_FMT_LSBJ) begin
          val = word << (6'h20 - w); // see (R1)
        end else begin
          val = (word << (6'h20 - slot)) & ~(32'hffffffff >> w); // see (R2)
        end
        // Keep the slot the select bit names; one means right.
        if (left != st_reg.chan[HSD_CH_SEL]) begin // see (R7)
          if (st_reg.pend_v && !fifo_in_ready) begin
            st_next.overrun = 1'b1;
          end else begin
            st_next.pend = val;
            st_next.pend_v = 1'b1;
          end
        end
      end
    end

    // Output stage loads from the FIFO head.
    if (fifo_out_ready) begin
      st_next.out_v = fifo_out_valid;
      st_next.out_d = fifo_out_data;
    end
    st_next.almost = (32'(fifo_cnt) >= 32'(st_reg.fmt[1:0]) + 32'd1); // see (R4)

    // Dwell tick at three kilohertz.
    st_next.tick = 1'b0;
    if (32'(st_reg.tick_cnt) >= TICK_CYCLES - 1) begin
      st_next.tick_cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
    end

    // Output protection: trip after the condition holds for the dwell.
    if (!op_cond) begin
      st_next.op_cnt = '0;
      st_next.op_trip = 1'b0;
    end else if (st_reg.op_cnt >= st_reg.oprot[6:0]) begin // see (R11)
      st_next.op_trip = 1'b1;
    end else if (st_reg.tick) begin
      st_next.op_cnt = st_reg.op_cnt + 1'b1;
    end

    // Input protection: same scheme with the eight-bit dwell.
    if (!ip_cond) begin
      st_next.ip_cnt = '0;
      st_next.ip_trip = 1'b0;
    end else if (st_reg.ip_cnt >= st_reg.iptime) begin // see (R14)
      st_next.ip_trip = 1'b1;
    end else if (st_reg.tick) begin
      st_next.ip_cnt = st_reg.ip_cnt + 1'b1;
    end
    st_next.pull = st_next.op_trip || st_next.ip_trip; // see (R10) see (R13)

    // Converter clock enable: base period doubled per code step.
    st_next.adc_en = 1'b0;
    if (32'(st_reg.adc_cnt) + 32'd1 >= (HSD_ADC_BASE_CYC << st_reg.diag[2:0])) begin // see (R15)
      st_next.adc_cnt = '0;
      st_next.adc_en = 1'b1;
    end else begin
      st_next.adc_cnt = st_reg.adc_cnt + 1'b1;
    end

    // Measurement sequencer; battery wins when both starts are set.
    case (st_reg.mstate)
      HSD_M_IDLE: begin
        if (st_reg.mstart[HSD_MS_BATT]) begin // see (R16)
          st_next.mpulse = 1'b1;
          st_next.mbatt = 1'b1;
          st_next.mstate = HSD_M_BATT;
        end else if (st_reg.mstart[HSD_MS_DIAG]) begin // see (R17)
          st_next.mpulse = 1'b1;
          st_next.mbatt = 1'b0;
          st_next.mstate = HSD_M_DIAG;
        end
      end
      HSD_M_BATT: begin
        if (meas_done) begin
          st_next.vb_code = meas_code; // see (R19) see (R21)
          st_next.mstart[HSD_MS_BATT] = 1'b0;
          st_next.mstate = HSD_M_IDLE;
        end
      end
      HSD_M_DIAG: begin
        if (meas_done) begin
          st_next.rl_code = meas_code; // see (R18) see (R21)
          st_next.mstart[HSD_MS_DIAG] = 1'b0;
          st_next.mstate = HSD_M_IDLE;
        end
      end
      default: begin
        st_next.mstate = HSD_M_IDLE;
      end
    endcase

    // Host writes come last, so a written start bit beats the clear.
    if (reg_wr) begin
      case (reg_addr)
        HSD_ADDR_FMT: st_next.fmt = reg_wdata;
        HSD_ADDR_CHAN: st_next.chan = reg_wdata;
        HSD_ADDR_OPROT: st_next.oprot = reg_wdata;
        HSD_ADDR_SHDN: st_next.shdn = reg_wdata;
        HSD_ADDR_IPLVL: st_next.iplvl = reg_wdata;
        HSD_ADDR_IPTIME: st_next.iptime = reg_wdata;
        HSD_ADDR_DIAG: st_next.diag = reg_wdata;
        HSD_ADDR_MSTART: st_next.mstart = reg_wdata;
        default: begin
        end
      endcase
    end

    // Read data; result registers ignore writes, unmapped reads give zero.
    if (reg_rd) begin
      case (reg_addr)
        HSD_ADDR_FMT: st_next.rdata = st_reg.fmt;
        HSD_ADDR_CHAN: st_next.rdata = st_reg.chan;
        HSD_ADDR_OPROT: st_next.rdata = st_reg.oprot;
        HSD_ADDR_SHDN: st_next.rdata = st_reg.shdn;
        HSD_ADDR_IPLVL: st_next.rdata = st_reg.iplvl;
        HSD_ADDR_IPTIME: st_next.rdata = st_reg.iptime;
        HSD_ADDR_DIAG: st_next.rdata = st_reg.diag;
        HSD_ADDR_MSTART: st_next.rdata = st_reg.mstart;
        HSD_ADDR_RLHI: st_next.rdata = st_reg.rl_code[9:2]; // see (R18)
        HSD_ADDR_VBHI: st_next.rdata = st_reg.vb_code[9:2]; // see (R19)
        HSD_ADDR_MLO: st_next.rdata = {2'h0, st_reg.vb_code[1:0], 2'h0, st_reg.rl_code[1:0]}; // see (R19)
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  // State register with documented reset values.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.fmt <= HSD_RST_FMT;
      st_reg.chan <= HSD_RST_CHAN;
      st_reg.oprot <= HSD_RST_OPROT;
      st_reg.shdn <= HSD_RST_SHDN;
      st_reg.iplvl <= HSD_RST_IPLVL;
      st_reg.iptime <= HSD_RST_IPTIME;
      st_reg.diag <= HSD_RST_DIAG;
      st_reg.mstart <= HSD_RST_MSTART;
      st_reg.mstate <= HSD_M_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state flops.
  assign reg_rdata = st_reg.rdata;
  assign sample_valid = st_reg.out_v;
  assign sample_data = st_reg.out_d;
  assign rx_almost_full = st_reg.almost;
  assign rx_overrun = st_reg.overrun;
  assign serial_play_active = st_reg.chan[HSD_CH_EN]; // see (R9)
  assign serial_preemptible = st_reg.chan[HSD_CH_INT]; // see (R8)
  assign bridge_pull_low = st_reg.pull;
  assign shutdown_full_wave = st_reg.shdn[HSD_SHDN_WAVE]; // see (R12)
  assign adc_clk_en = st_reg.adc_en;
  assign meas_start = st_reg.mpulse;
  assign meas_battery = st_reg.mbatt;
  assign diagnostic_kind_sel = st_reg.diag[HSD_DIAG_KIND];

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_BATT_START: assert property (st_reg.mstate == HSD_M_IDLE && st_reg.mstart[1] // see (R16)
                                   |=> meas_start && meas_battery)
    else $error("Battery start bit did not launch a battery measurement.");
  AST_DIAG_START: assert property (st_reg.mstate == HSD_M_IDLE && st_reg.mstart[1:0] == 2'h1 // see (R17)
                                   |=> meas_start && !meas_battery)
    else $error("Diagnostic start bit did not launch a resistance measurement.");
  AST_RL_HOLD: assert property (!(meas_done && st_reg.mstate == HSD_M_DIAG) |=> $stable(st_reg.rl_code)) // see (R21)
    else $error("Resistance result changed without a finished diagnostic.");
  AST_RL_LOAD: assert property (meas_done && st_reg.mstate == HSD_M_DIAG // see (R18)
                                |=> st_reg.rl_code == $past(meas_code))
    else $error("Resistance result not captured.");
  AST_LO_READ: assert property (reg_rd && reg_addr == HSD_ADDR_MLO // see (R19)
                                |=> reg_rdata == {2'h0, $past(st_reg.vb_code[1:0]), 2'h0,
                                                  $past(st_reg.rl_code[1:0])})
    else $error("Shared low-bits register read wrong.");
  AST_OPROT_TRIP: assert property (st_reg.oprot[7] && st_reg.oprot[6:0] == 7'h00 && pos_level >= 7'd124 // see (R10)
                                   |=> bridge_pull_low)
    else $error("Output protection did not pull the bridge low.");
  AST_NO_TRIP: assert property ((pos_level < 7'd124 && neg_level < 7'd124 && !st_reg.iplvl[7]) // see (R10)
                                |=> !st_reg.op_trip)
    else $error("Output protection tripped below its level.");
  AST_PROT_OFF: assert property ((!st_reg.oprot[7] && !st_reg.iplvl[7])[*2] |-> !bridge_pull_low) // see (R13)
    else $error("Bridge pulled low with protection disabled.");
  AST_ALMOST: assert property (1'b1 |=> rx_almost_full == // see (R4)
                               (32'($past(fifo_cnt)) >= 32'($past(st_reg.fmt[1:0])) + 32'd1))
    else $error("Almost-full flag does not match the fill threshold.");
  AST_DISABLED: assert property (!st_reg.chan[0] |=> !st_reg.pend_v) // see (R9)
    else $error("Receiver produced a word while disabled.");
  AST_ADC_GAP: assert property (adc_clk_en |=> !adc_clk_en) // see (R15)
    else $error("Converter clock enable ran on consecutive cycles.");

  COV_BATT: cover property (meas_start && meas_battery);
  COV_TRIP: cover property (bridge_pull_low);
  COV_ALMOST: cover property (rx_almost_full);
  COV_PUSH: cover property (st_reg.pend_v && fifo_in_ready);
endmodule : hsd_regbank
`default_nettype wire

// *** verif/hsd_i2s_src.sv ***
// Serial audio source model that plays one stereo frame on request.
`default_nettype none
module hsd_i2s_src (
  // Serial audio pins.
  output logic bck,
  output logic ws,
  output logic sd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit clock polarity and MSB-justified framing, chosen by the bench before a frame.
  logic inv = 1'b0;
  logic mj = 1'b0;
  // Frame of 64 data bits in 66 bit clocks; the bit clock rests at its idle level between frames.
  task automatic send(input logic [31:0] l, input logic [31:0] r);
    logic [63:0] f;
    f = {l, r};
    for (int i = -1; i < 65; i++) begin
      ws = mj ? (i < 32 || i > 63) : (i >= 31 && i < 63);
      sd = (i >= 0 && i < 64) ? f[63-i] : ~sd;
      #160 bck = ~inv;
      #160 bck = inv;
    end
    sd = ~sd;
  endtask : send
  // Idle levels at time zero.
  initial begin
    bck = 1'b0;
    ws = 1'b0;
    sd = 1'b0;
  end
endmodule : hsd_i2s_src
`default_nettype wire

// *** verif/test_hsd_regbank.sv ***
// Self-checking bench for the haptic register bank.
`default_nettype none
module test_hsd_regbank;
  import hsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sample_ready = 1'b0, meas_done = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] pos_level = 7'h00, neg_level = 7'h00;
  logic [9:0] meas_code = 10'h000;
  logic bck, ws, sd, sample_valid, rx_almost_full, bridge_pull_low, meas_start, serial_play_active;
  logic serial_preemptible, shutdown_full_wave, adc_clk_en, meas_battery, diagnostic_kind_sel, share = 1'b0;
  logic [31:0] sample_data;
  // Reset register table: addresses and values.
  logic [7:0] ra [11] = '{8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h51, 8'h52, 8'h53, 8'h55, 8'h57};
  logic [7:0] rv [11] = '{8'h3a, 8'h06, 8'ha0, 8'h28, 8'hbf, 8'h32, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares = 0, n_tests = 0, a0 = 0;
  always #20 clock = ~clock;
  hsd_regbank #(.TICK_CYCLES(4), .FIFO_DEPTH(8)) DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bck_pin(bck),
    .ws_pin(ws & !share), .sd_pin(sd & !share), .third_trigger_pin(sd & share), .second_trigger_pin(ws & share),
    .serial_pin_share(share), .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .rx_almost_full(rx_almost_full), .rx_overrun(), .serial_play_active(serial_play_active),
    .serial_preemptible(serial_preemptible), .pos_level(pos_level), .neg_level(neg_level),
    .bridge_pull_low(bridge_pull_low), .shutdown_full_wave(shutdown_full_wave), .adc_clk_en(adc_clk_en),
    .meas_start(meas_start), .meas_battery(meas_battery), .diagnostic_kind_sel(diagnostic_kind_sel),
    .meas_done(meas_done), .meas_code(meas_code));
  hsd_i2s_src src (.bck(bck), .ws(ws), .sd(sd));
  // Compares one result and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  // Register write and read strobes last one cycle each.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, reg_rdata});
  endtask : rd
  // Waits for a word, checks it and takes it.
  task automatic get(input logic [31:0] exp);
    @(negedge clock);
    for (int i = 0; i < 50 && sample_valid !== 1'b1; i++) @(negedge clock);
    chk("sample_valid", 1, sample_valid);
    chk("sample_data", exp, sample_data);
    sample_ready = 1'b1;
    @(negedge clock);
    sample_ready = 1'b0;
  endtask : get
  // Starts a conversion and plays the converter finishing it.
  task automatic meas(input logic [7:0] go, input logic [9:0] code);
    wr(HSD_ADDR_MSTART, go);
    for (int i = 0; i < 20 && meas_start !== 1'b1; i++) @(negedge clock);
    chk("meas_start", {30'h0, 1'b1, go[1]}, {30'h0, meas_start, meas_battery});
    cyc(3);
    meas_code = code;
    meas_done = 1'b1;
    cyc(1);
    meas_done = 1'b0;
    rd(HSD_ADDR_MSTART, 8'h00); // Start bit clears itself
  endtask : meas
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  initial begin
    cyc(20000);
    miscompares++;
    end_sim();
  end
  initial begin
    cyc(4);
    rst_n = 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h53, 8'hff);
    rd(8'h53, 8'h00); // Result is read-only
    rd(8'h50, 8'h00);
    // Converter clock pulses over 64 cycles at the reset divider code of 2.
    repeat (64) begin
      @(negedge clock);
      a0 += int'(adc_clk_en);
    end
    chk("adc", 64 / (HSD_ADC_BASE_CYC << 2), a0);
    wr(8'h51, 8'h12);
    chk("kind", 1, diagnostic_kind_sel);
    wr(8'h4d, 8'h38);
    chk("wave", 1, shutdown_full_wave);
    wr(8'h4b, 8'h07);
    chk("play", 1, serial_play_active);
    chk("int", 1, serial_preemptible);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      src.send(32'h0, 32'ha5000000 + k);
      cyc(8);
      if (k == 2) chk("af", 0, rx_almost_full);
    end
    chk("af", 1, rx_almost_full);
    for (int k = 0; k < 4; k++) get(32'ha5000000 + k);
    wr(8'h4b, 8'h03);
    src.send(32'h1234abcd, 32'h0);
    get(32'h1234abcd);
    share = 1'b1;
    wr(8'h4b, 8'h13);
    src.send(32'h0, 32'h0f0f0f0f);
    get(32'h0f0f0f0f);
    // MSB-justified 16-bit samples taken on the falling bit clock edge.
    src.inv = 1'b1;
    src.mj = 1'b1;
    wr(8'h4a, 8'h4a);
    wr(8'h4b, 8'h0b);
    src.send(32'h89abcdef, 32'h0);
    get(32'h89ab0000);
    wr(8'h4b, 8'h10);
    chk("int", 0, serial_preemptible);
    src.send(32'h1, 32'h2);
    cyc(8);
    chk("valid", 0, sample_valid);
    $display("test serial done");
    wr(8'h4e, 8'h3f);
    wr(8'h4c, 8'h80);
    pos_level = 7'd123;
    cyc(4);
    chk("pull", 0, bridge_pull_low);
    pos_level = 7'd124;
    cyc(3);
    chk("pull", 1, bridge_pull_low);
    wr(8'h4c, 8'h00);
    wr(8'h4f, 8'h02);
    wr(8'h4e, 8'h8a);
    pos_level = 7'd0;
    neg_level = 7'd10;
    cyc(2);
    chk("pull", 0, bridge_pull_low);
    cyc(12);
    chk("pull", 1, bridge_pull_low);
    neg_level = 7'd0;
    wr(8'h4e, 8'h0a);
    chk("pull", 0, bridge_pull_low);
    $display("test protection done");
    meas(8'h02, 10'h2a5);
    rd(8'h55, 8'ha9);
    meas(8'h01, 10'h1b6);
    rd(8'h53, 8'h6d);
    rd(8'h57, 8'h12);
    $display("test measurement done");
    end_sim();
  end
endmodule : test_hsd_regbank
`default_nettype wire
